// File: rtl/srts_pkg.sv
package srts_pkg;
   // timeout build options, one per documented range
   typedef enum logic [1:0] {
      SRTS_TMO_1MS = 2'h0,
      SRTS_TMO_20MS = 2'h1,
      SRTS_TMO_100MS = 2'h2,
      SRTS_TMO_140MS = 2'h3
   } srts_tmo_type;

   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned NS_PER_S = 1_000_000_000;
   // least reset hold times per option, in microseconds
   localparam int unsigned HOLD_1MS_US = 1000;
   localparam int unsigned HOLD_20MS_US = 20000;
   localparam int unsigned HOLD_100MS_US = 100000;
   localparam int unsigned HOLD_140MS_US = 140000;
   localparam int unsigned US_PER_S = 1_000_000;
   localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
   localparam int unsigned HOLD_1MS_CYC = HOLD_1MS_US * CYC_PER_US;
   localparam int unsigned HOLD_20MS_CYC = HOLD_20MS_US * CYC_PER_US;
   localparam int unsigned HOLD_100MS_CYC = HOLD_100MS_US * CYC_PER_US;
   localparam int unsigned HOLD_140MS_CYC = HOLD_140MS_US * CYC_PER_US;
   // glitch rejection: dips up to this long are ignored
   localparam int unsigned GLITCH_NS = 5000;
   localparam int unsigned GLITCH_CYC = (GLITCH_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned CNT_W = 24;
   localparam int unsigned GL_W = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
   localparam logic [GL_W-1:0] GL_ZERO = 8'h00;
   localparam logic [GL_W-1:0] GL_ONE = 8'h01;
endpackage

// File: rtl/srts_supervisor.sv
module srts_supervisor #(
   parameter srts_pkg::srts_tmo_type TMO_SEL = srts_pkg::SRTS_TMO_140MS,
   parameter int unsigned HOLD_CYC = (TMO_SEL == srts_pkg::SRTS_TMO_1MS) ?
      srts_pkg::HOLD_1MS_CYC : (TMO_SEL == srts_pkg::SRTS_TMO_20MS) ?
      srts_pkg::HOLD_20MS_CYC : (TMO_SEL == srts_pkg::SRTS_TMO_100MS) ?
      srts_pkg::HOLD_100MS_CYC : srts_pkg::HOLD_140MS_CYC,
   parameter int unsigned GLITCH_CYC = srts_pkg::GLITCH_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic supply_ok,
   output logic host_reset_n,
   output logic host_reset
);
   // counter widths are read once from the package
   localparam int unsigned CNT_W = srts_pkg::CNT_W;
   localparam int unsigned GL_W = srts_pkg::GL_W;
   // three stages: a slow comparator edge cannot reach logic half-settled
   localparam int unsigned SYNC_STAGES = 3;
   localparam int unsigned SYNC_FIRST = 0;
   localparam int unsigned SYNC_MID = SYNC_STAGES - 2;
   localparam int unsigned SYNC_LAST = SYNC_STAGES - 1;

   // one-hot: any corrupted code falls back to holding reset
   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_HOLD = 3'b010,
      ST_RUN = 3'b100
   } srts_state_type;

   // comparator side
   logic [SYNC_STAGES-1:0] sync_q;
   logic stages_agree;
   logic ok_q;

   // glitch filter
   logic [GL_W-1:0] low_cnt_q;
   logic [GL_W-1:0] gl_last;
   logic low_full;
   logic brown_q;

   // timeout count
   logic [CNT_W-1:0] hold_cnt_q;
   logic [CNT_W-1:0] hold_last;
   logic hold_full;
   logic hold_clear;

   // sequencing
   srts_state_type state_q;
   srts_state_type state_d;
   logic run_d;

   // least value of the chosen range, so release is never early
   assign hold_last = CNT_W'(HOLD_CYC - 1);
   assign gl_last = GL_W'(GLITCH_CYC);

   for (genvar i = 0; i < SYNC_STAGES; i++) begin : g_sync
      if (i == SYNC_FIRST) begin : g_first
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               sync_q[i] <= 1'b0;
            end else begin
               sync_q[i] <= supply_ok;
            end
         end
      end else begin : g_next
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               sync_q[i] <= 1'b0;
            end else begin
               sync_q[i] <= sync_q[i-1];
            end
         end
      end
   end

   // a level counts only once the last two stages agree,
   // so a change caught mid-sample is never taken
   always_comb begin
      stages_agree = 1'b0;
      if (sync_q[SYNC_MID] == sync_q[SYNC_LAST]) begin
         stages_agree = 1'b1;
      end
   end

   // holds its level while the stages disagree
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ok_q <= 1'b0;
      end else if (stages_agree) begin
         ok_q <= sync_q[SYNC_LAST];
      end
   end

   // low must last longer than the glitch window to count as brownout
   always_comb begin
      low_full = 1'b0;
      if (low_cnt_q >= gl_last) begin
         low_full = 1'b1;
      end
   end

   // saturates at the window so it never wraps back to zero
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         low_cnt_q <= srts_pkg::GL_ZERO;
      end else if (ok_q) begin
         low_cnt_q <= srts_pkg::GL_ZERO;
      end else if (!low_full) begin
         low_cnt_q <= low_cnt_q + srts_pkg::GL_ONE;
      end
   end

   // starts in brownout: nothing is trusted until the supply is seen ok
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         brown_q <= 1'b1;
      end else if (ok_q) begin
         brown_q <= 1'b0;
      end else if (low_full) begin
         brown_q <= 1'b1;
      end
   end

   // counter only runs while holding; any brownout restarts from zero
   always_comb begin
      hold_full = 1'b0;
      if (hold_cnt_q >= hold_last) begin
         hold_full = 1'b1;
      end
   end

   // clears on any brownout, even mid-count
   always_comb begin
      hold_clear = 1'b1;
      if (state_q == ST_HOLD && !brown_q) begin
         hold_clear = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hold_cnt_q <= srts_pkg::CNT_ZERO;
      end else if (hold_clear) begin
         hold_cnt_q <= srts_pkg::CNT_ZERO;
      end else begin
         hold_cnt_q <= hold_cnt_q + srts_pkg::CNT_ONE;
      end
   end

   // a brownout wins over a finished count
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RESET: begin
            if (!brown_q) begin
               state_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (brown_q) begin
               state_d = ST_RESET;
            end else if (hold_full) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (brown_q) begin
               state_d = ST_RESET;
            end
         end
         default: begin
            state_d = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // outputs follow the next state so release lands on the same edge
   always_comb begin
      run_d = 1'b0;
      case (state_d)
         ST_RUN: begin
            run_d = 1'b1;
         end
         default: begin
            run_d = 1'b0;
         end
      endcase
   end

   // two flops, not one inverted: each pin launches from its own register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         host_reset_n <= 1'b0;
      end else begin
         host_reset_n <= run_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         host_reset <= 1'b1;
      end else begin
         host_reset <= !run_d;
      end
   end
endmodule

// File: verification/srts_sva.sv
module srts_sva #(parameter int HOLD_CYC = 20, GLITCH_CYC = 4) (
   input wire logic clk_sys, sys_rst, supply_ok, host_reset_n, host_reset);
   timeunit 1ns / 100ps;
   int hi_q, lo_q;
   always_ff @(posedge clk_sys) hi_q <= sys_rst || !supply_ok ? 0 : hi_q + 1;
   always_ff @(posedge clk_sys) lo_q <= sys_rst || supply_ok ? 0 : lo_q + 1;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_pol_pair: assert property (host_reset != host_reset_n) else $error("pair");
   a_stay_off: assert property (hi_q > HOLD_CYC + 9 |-> host_reset_n) else $error("on");
   a_brown_on: assert property (lo_q > GLITCH_CYC + 7 |-> !host_reset_n) else $error("off");
   a_hold_full: assert property ($rose(host_reset_n) |-> hi_q >= HOLD_CYC)
      else $error("early");
   a_hold_late: assert property ($rose(host_reset_n) |-> hi_q <= HOLD_CYC + 10)
      else $error("late");
   a_glitch_ign: assert property (host_reset_n && $rose(supply_ok) && lo_q < GLITCH_CYC - 1
      |-> host_reset_n [*6]) else $error("dip");
   c_up: cover property ($rose(host_reset_n));
   c_down: cover property ($fell(host_reset_n));
   c_dip: cover property ($rose(supply_ok) && lo_q == 2);
endmodule
bind srts_supervisor srts_sva #(.HOLD_CYC(HOLD_CYC), .GLITCH_CYC(GLITCH_CYC)) i_sva (.clk_sys,
   .sys_rst, .supply_ok, .host_reset_n, .host_reset);

// File: verification/srts_host_model.sv
module srts_host_model (
   input wire logic clk_sys, host_reset_n, host_reset,
   output logic host_run);
   timeunit 1ns / 100ps;
   // runs only when both polarities agree, so a split pair shows up
   always_ff @(posedge clk_sys) host_run <= host_reset_n && !host_reset;
endmodule

// File: verification/tb.sv
module tb;
   timeunit 1ns / 100ps;
   localparam int HC = 20, GC = 4;
   logic clk_sys = 0, sys_rst = 1, supply_ok = 0, host_reset_n, host_reset, host_run;
   int fails = 0, compares = 0, cyc = 0, n;
   always #12.5 clk_sys = ~clk_sys;
   srts_supervisor #(.HOLD_CYC(HC), .GLITCH_CYC(GC)) i_dut (.clk_sys, .sys_rst, .supply_ok,
      .host_reset_n, .host_reset);
   srts_host_model i_host (.clk_sys, .host_reset_n, .host_reset, .host_run);
   task chk(logic ok);
      compares++;
      if (ok !== 1'b1) fails++;
      $display("%s %0t test %0d", ok === 1'b1 ? "done" : "mismatch", $time, compares);
   endtask
   task dip(int k);
      @(posedge clk_sys) supply_ok <= 1'b0;
      repeat (k) @(posedge clk_sys);
      @(posedge clk_sys) supply_ok <= 1'b1;
   endtask
   task up;
      for (n = 0; host_reset_n !== 1'b1 && n < HC + 20; n++) @(negedge clk_sys);
      chk(n >= HC && n <= HC + 10 && host_reset === 1'b0);
   endtask
   task stop_test(int t);
      fails += t;
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task t_power_up;
      dip(0);
      up();
   endtask
   task t_glitch;
      dip(GC - 3);
      repeat (10) @(negedge clk_sys);
      chk(host_run === 1'b1);
   endtask
   task t_brownout;
      dip(GC + 10);
      repeat (HC / 2) @(negedge clk_sys);
      chk({host_reset_n, host_reset} === 2'h1);
   endtask
   task t_restart;
      dip(GC + 10);
      up();
   endtask
   always @(posedge clk_sys) if (cyc++ > 900) stop_test(1);
   initial begin
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_power_up();
      t_glitch();
      t_brownout();
      t_restart();
      stop_test(0);
   end
endmodule
